// ---- common/cgal_pkg.sv ----
package cgal_pkg;
	// ==========================================================
	// Register offsets (byte registers).
	localparam logic [4:0] OFS_STAT   = 5'h00;
	localparam logic [4:0] OFS_CTRL   = 5'h01;
	localparam logic [4:0] OFS_ACR_HI = 5'h02;
	localparam logic [4:0] OFS_ACR_LO = 5'h03;
	localparam logic [4:0] OFS_QTH_HM = 5'h04;
	localparam logic [4:0] OFS_QTH_HL = 5'h05;
	localparam logic [4:0] OFS_QTH_LM = 5'h06;
	localparam logic [4:0] OFS_QTH_LL = 5'h07;
	localparam logic [4:0] OFS_VOLT_M = 5'h08;
	localparam logic [4:0] OFS_VOLT_L = 5'h09;
	localparam logic [4:0] OFS_VTH_HI = 5'h0a;
	localparam logic [4:0] OFS_VTH_LO = 5'h0b;
	localparam logic [4:0] OFS_TEMP_M = 5'h0c;
	localparam logic [4:0] OFS_TEMP_L = 5'h0d;
	localparam logic [4:0] OFS_TTH_HI = 5'h0e;
	localparam logic [4:0] OFS_TTH_LO = 5'h0f;
	localparam logic [4:0] OFS_IRQ_ST = 5'h10;
	localparam logic [4:0] OFS_IRQ_MK = 5'h11;

	// ==========================================================
	// Field positions.
	localparam int ST_CHIP  = 7;
	localparam int ST_OVF   = 5;
	localparam int ST_TEMP  = 4;
	localparam int ST_QHI   = 3;
	localparam int ST_QLO   = 2;
	localparam int ST_VOLT  = 1;
	localparam int CT_ADC_H = 7;
	localparam int CT_ADC_L = 6;
	localparam int CT_PSC_H = 5;
	localparam int CT_PSC_L = 3;
	localparam int CT_PIN_H = 2;
	localparam int CT_PIN_L = 1;
	localparam int CT_SHDN  = 0;
	localparam int IRQ_W    = 4;
	localparam int IQ_LIM   = 0;
	localparam int IQ_OVF   = 1;
	localparam int IQ_CDONE = 2;
	localparam int IQ_CONV  = 3;

	// ==========================================================
	// Pin function codes and reset values.
	localparam logic [1:0]  PIN_OFF   = 2'h0;
	localparam logic [1:0]  PIN_CDONE = 2'h1;
	localparam logic [1:0]  PIN_ALERT = 2'h2;
	localparam logic [7:0]  CTRL_RST  = 8'h3c;
	localparam logic [15:0] ACR_RST   = 16'h7fff;
	localparam logic [15:0] ACR_FULL  = 16'hffff;
	localparam logic [15:0] ACR_EMPTY = 16'h0000;
	localparam logic [15:0] LIM_HI16  = 16'hffff;
	localparam logic [15:0] LIM_LO16  = 16'h0000;
	localparam logic [7:0]  LIM_HI8   = 8'hff;
	localparam logic [7:0]  LIM_LO8   = 8'h00;
	localparam logic [15:0] VOLT_MASK = 16'hfffc;
	localparam logic [15:0] TEMP_MASK = 16'hffc0;
	// Arbitrary value for the chip identification bit.
	localparam logic        CHIP_ID   = 1'b0;
endpackage : cgal_pkg

// ---- rtl/cgal_sync.sv ----
`timescale 1ns/1ns
module cgal_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	always_comb begin
		meta_nxt = d;
		q_nxt    = meta_r;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= meta_nxt;
			q      <= q_nxt;
		end
	end
endmodule : cgal_sync

// ---- rtl/cgal_top.sv ----
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ns
module cgal_top
	import cgal_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        integ_clk,
	input  wire logic        integ_up,
	input  wire logic [15:0] adc_volt,
	input  wire logic        adc_volt_vld,
	input  wire logic [15:0] adc_temp,
	input  wire logic        adc_temp_vld,
	output logic      [1:0]  adc_mode,
	output logic             shutdown,
	input  wire logic        alert_or_charge_done_pin_i,
	output logic             alert_or_charge_done_pin_o,
	output logic             alert_or_charge_done_pin_oe_n,
	output logic             irq
);
	// ==========================================================
	// State.
	logic [7:0]       ctrl_r, ctrl_nxt;
	logic [7:0]       stat_r, stat_nxt;
	logic [15:0]      acr_r, acr_nxt;
	logic [15:0]      qth_hi_r, qth_hi_nxt, qth_lo_r, qth_lo_nxt;
	logic [15:0]      volt_r, volt_nxt, temp_r, temp_nxt;
	logic [7:0]       vth_hi_r, vth_hi_nxt, vth_lo_r, vth_lo_nxt;
	logic [7:0]       tth_hi_r, tth_hi_nxt, tth_lo_r, tth_lo_nxt;
	logic [6:0]       psc_r, psc_nxt;
	logic             iclk_d_r, iclk_d_nxt;
	logic             cdone_d_r, cdone_d_nxt;
	logic [IRQ_W-1:0] ist_r, ist_nxt, imk_r, imk_nxt;
	logic [7:0]       rdata_nxt;

	logic [2:0]       sync_q;
	logic             iclk_s, iup_s, cdone_s;
	logic             step, cdone_hold, ovf_ev, sat_now;
	logic             c_qhi, c_qlo, c_volt, c_temp, rd_stat;
	logic [6:0]       psc_top;
	logic [1:0]       pin_fn;
	logic [4:0]       lim_set;
	logic [IRQ_W-1:0] iev;

	// ==========================================================
	// Inputs from outside the clock domain.
	// The integrator clock is slow, so finding its edges on clk is cheaper
	// than running a second domain.
	cgal_sync #(.W(3)) u_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.d       ({integ_clk, integ_up, alert_or_charge_done_pin_i}),
		.q       (sync_q)
	);
	assign iclk_s  = sync_q[2];
	assign iup_s   = sync_q[1];
	assign cdone_s = sync_q[0];

	// ==========================================================
	// Limit comparisons.
	assign pin_fn  = ctrl_r[CT_PIN_H:CT_PIN_L];
	assign c_qhi   = acr_r > qth_hi_r;
	assign c_qlo   = acr_r < qth_lo_r;
	assign c_volt  = (volt_r[15:8] > vth_hi_r) || (volt_r[15:8] < vth_lo_r);
	assign c_temp  = (temp_r[15:8] > tth_hi_r) || (temp_r[15:8] < tth_lo_r);
	assign sat_now = (acr_r == ACR_FULL) || (acr_r == ACR_EMPTY);
	assign rd_stat = reg_rd && (reg_addr == OFS_STAT);
	// Only the charge-done function forces the count to full; code 11 acts as off.
	assign cdone_hold = (pin_fn == PIN_CDONE) && cdone_s;
	assign psc_top = 7'((8'h01 << ctrl_r[CT_PSC_H:CT_PSC_L]) - 8'h01);
	assign step    = iclk_s && !iclk_d_r && !ctrl_r[CT_SHDN];

	// ==========================================================
	// Charge counting and result capture.
	always_comb begin
		ctrl_nxt    = ctrl_r;
		acr_nxt     = acr_r;
		qth_hi_nxt  = qth_hi_r;
		qth_lo_nxt  = qth_lo_r;
		volt_nxt    = volt_r;
		temp_nxt    = temp_r;
		vth_hi_nxt  = vth_hi_r;
		vth_lo_nxt  = vth_lo_r;
		tth_hi_nxt  = tth_hi_r;
		tth_lo_nxt  = tth_lo_r;
		psc_nxt     = psc_r;
		iclk_d_nxt  = iclk_s;
		cdone_d_nxt = cdone_hold;
		imk_nxt     = imk_r;
		ovf_ev      = 1'b0;
		if (reg_wr) begin
			case (reg_addr)
				OFS_CTRL:   ctrl_nxt          = reg_wdata;
				OFS_ACR_HI: acr_nxt[15:8]     = reg_wdata;
				OFS_ACR_LO: acr_nxt[7:0]      = reg_wdata;
				OFS_QTH_HM: qth_hi_nxt[15:8]  = reg_wdata;
				OFS_QTH_HL: qth_hi_nxt[7:0]   = reg_wdata;
				OFS_QTH_LM: qth_lo_nxt[15:8]  = reg_wdata;
				OFS_QTH_LL: qth_lo_nxt[7:0]   = reg_wdata;
				OFS_VTH_HI: vth_hi_nxt        = reg_wdata;
				OFS_VTH_LO: vth_lo_nxt        = reg_wdata;
				OFS_TTH_HI: tth_hi_nxt        = reg_wdata;
				OFS_TTH_LO: tth_lo_nxt        = reg_wdata;
				OFS_IRQ_MK: imk_nxt           = reg_wdata[IRQ_W-1:0];
				default: ;
			endcase
		end
		if (cdone_hold) begin
			acr_nxt = ACR_FULL;
			psc_nxt = '0;
		end else if (step) begin
			// One charge count per M integrator reversals in one direction.
			if (iup_s) begin
				if (psc_r >= psc_top) begin
					psc_nxt = '0;
					if (acr_r == ACR_FULL) begin
						ovf_ev = 1'b1;
					end else begin
						acr_nxt = acr_r + 16'h0001;
					end
				end else begin
					psc_nxt = psc_r + 7'h01;
				end
			end else begin
				if (psc_r == 7'h00) begin
					psc_nxt = psc_top;
					if (acr_r == ACR_EMPTY) begin
						ovf_ev = 1'b1;
					end else begin
						acr_nxt = acr_r - 16'h0001;
					end
				end else begin
					psc_nxt = psc_r - 7'h01;
				end
			end
		end
		if (adc_volt_vld) begin
			volt_nxt = adc_volt & VOLT_MASK;
		end
		if (adc_temp_vld) begin
			temp_nxt = adc_temp & TEMP_MASK;
		end
	end

	// ==========================================================
	// Status flags, interrupt and read data.
	// A read clears a flag only when its cause is gone; a cause present in
	// the same cycle keeps it set.
	always_comb begin
		lim_set = {ovf_ev, c_temp, c_qhi, c_qlo, c_volt};
		stat_nxt = stat_r;
		stat_nxt[ST_CHIP] = CHIP_ID;
		stat_nxt[6] = 1'b0;
		stat_nxt[0] = 1'b0;
		if (rd_stat) begin
			stat_nxt[ST_OVF]  = stat_r[ST_OVF] && sat_now;
			stat_nxt[ST_TEMP] = stat_r[ST_TEMP] && c_temp;
			stat_nxt[ST_QHI]  = stat_r[ST_QHI] && c_qhi;
			stat_nxt[ST_QLO]  = stat_r[ST_QLO] && c_qlo;
			stat_nxt[ST_VOLT] = stat_r[ST_VOLT] && c_volt;
		end
		stat_nxt[ST_OVF:ST_VOLT] = stat_nxt[ST_OVF:ST_VOLT] | lim_set;
		iev = '0;
		iev[IQ_LIM]   = |(lim_set[3:0] & ~stat_r[ST_TEMP:ST_VOLT]);
		iev[IQ_OVF]   = ovf_ev;
		iev[IQ_CDONE] = cdone_hold && !cdone_d_r;
		iev[IQ_CONV]  = adc_volt_vld || adc_temp_vld;
		ist_nxt = ist_r;
		if (reg_wr && (reg_addr == OFS_IRQ_ST)) begin
			ist_nxt = ist_r & ~reg_wdata[IRQ_W-1:0];
		end
		ist_nxt = ist_nxt | iev;
		rdata_nxt = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				OFS_STAT:   rdata_nxt = stat_r;
				OFS_CTRL:   rdata_nxt = ctrl_r;
				OFS_ACR_HI: rdata_nxt = acr_r[15:8];
				OFS_ACR_LO: rdata_nxt = acr_r[7:0];
				OFS_QTH_HM: rdata_nxt = qth_hi_r[15:8];
				OFS_QTH_HL: rdata_nxt = qth_hi_r[7:0];
				OFS_QTH_LM: rdata_nxt = qth_lo_r[15:8];
				OFS_QTH_LL: rdata_nxt = qth_lo_r[7:0];
				OFS_VOLT_M: rdata_nxt = volt_r[15:8];
				OFS_VOLT_L: rdata_nxt = volt_r[7:0];
				OFS_VTH_HI: rdata_nxt = vth_hi_r;
				OFS_VTH_LO: rdata_nxt = vth_lo_r;
				OFS_TEMP_M: rdata_nxt = temp_r[15:8];
				OFS_TEMP_L: rdata_nxt = temp_r[7:0];
				OFS_TTH_HI: rdata_nxt = tth_hi_r;
				OFS_TTH_LO: rdata_nxt = tth_lo_r;
				OFS_IRQ_ST: rdata_nxt = {{(8-IRQ_W){1'b0}}, ist_r};
				OFS_IRQ_MK: rdata_nxt = {{(8-IRQ_W){1'b0}}, imk_r};
				default:    rdata_nxt = 8'h00;
			endcase
		end
	end

	// ==========================================================
	// Registers.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctrl_r    <= CTRL_RST;
			stat_r    <= 8'h00;
			acr_r     <= ACR_RST;
			qth_hi_r  <= LIM_HI16;
			qth_lo_r  <= LIM_LO16;
			volt_r    <= 16'h0000;
			temp_r    <= 16'h0000;
			vth_hi_r  <= LIM_HI8;
			vth_lo_r  <= LIM_LO8;
			tth_hi_r  <= LIM_HI8;
			tth_lo_r  <= LIM_LO8;
			psc_r     <= 7'h00;
			iclk_d_r  <= 1'b0;
			cdone_d_r <= 1'b0;
			ist_r     <= '0;
			imk_r     <= '0;
			reg_rdata <= 8'h00;
		end else begin
			ctrl_r    <= ctrl_nxt;
			stat_r    <= stat_nxt;
			acr_r     <= acr_nxt;
			qth_hi_r  <= qth_hi_nxt;
			qth_lo_r  <= qth_lo_nxt;
			volt_r    <= volt_nxt;
			temp_r    <= temp_nxt;
			vth_hi_r  <= vth_hi_nxt;
			vth_lo_r  <= vth_lo_nxt;
			tth_hi_r  <= tth_hi_nxt;
			tth_lo_r  <= tth_lo_nxt;
			psc_r     <= psc_nxt;
			iclk_d_r  <= iclk_d_nxt;
			cdone_d_r <= cdone_d_nxt;
			ist_r     <= ist_nxt;
			imk_r     <= imk_nxt;
			reg_rdata <= rdata_nxt;
		end
	end

	// ==========================================================
	// Outputs.
	// The pin is open drain: it only ever drives low, and is released
	// whenever no limit flag is pending.
	assign alert_or_charge_done_pin_o    = 1'b0;
	assign alert_or_charge_done_pin_oe_n =
		!((pin_fn == PIN_ALERT) && |stat_r[ST_TEMP:ST_VOLT]);
	assign adc_mode = ctrl_r[CT_ADC_H:CT_ADC_L];
	assign shutdown = ctrl_r[CT_SHDN];
	assign irq      = |(ist_r & imk_r);
endmodule : cgal_top

// ---- bench/cgal_chk.sv ----
`timescale 1ns/1ns
module cgal_chk
	import cgal_pkg::*;
(
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [1:0] adc_mode,
	input wire logic       shutdown,
	input wire logic       alert_or_charge_done_pin_o,
	input wire logic       alert_or_charge_done_pin_oe_n
);
	// ====================
	// Bus, control and pin relations.
	wire en_n = alert_or_charge_done_pin_oe_n;
	wire c_wr = reg_wr && reg_addr == OFS_CTRL;
	wire s_rd = reg_rd && reg_addr == OFS_STAT;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_pin_open_drain: assert property (!alert_or_charge_done_pin_o)
		else $error("pin driven high");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not idle");
	a_ctrl_outputs: assert property (c_wr |=> shutdown == $past(reg_wdata[0])
		&& adc_mode == $past(reg_wdata[7:6])) else $error("control outputs wrong");
	a_pin_released: assert property (c_wr && reg_wdata[2:1] != PIN_ALERT |=> en_n)
		else $error("pin pulled outside alert mode");
	a_alert_flagged: assert property (s_rd && !en_n |=> reg_rdata[4:1] != 4'h0)
		else $error("alert without status flag");
	a_status_fixed: assert property (s_rd |=> reg_rdata[7:6] == {CHIP_ID, 1'b0}
		&& !reg_rdata[0]) else $error("status fixed bits wrong");
	a_volt_mask: assert property (reg_rd && reg_addr == OFS_VOLT_L |=>
		reg_rdata[1:0] == 2'h0) else $error("voltage low bits set");
	a_temp_mask: assert property (reg_rd && reg_addr == OFS_TEMP_L |=>
		reg_rdata[5:0] == 6'h00) else $error("temperature low bits set");
endmodule : cgal_chk

bind cgal_top cgal_chk u_chk (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.adc_mode(adc_mode), .shutdown(shutdown),
	.alert_or_charge_done_pin_o(alert_or_charge_done_pin_o),
	.alert_or_charge_done_pin_oe_n(alert_or_charge_done_pin_oe_n));

// ---- bench/cgal_far_model.sv ----
`timescale 1ns/1ns
module cgal_far_model (
	input  wire logic run,
	input  wire logic up,
	input  wire logic chg_en,
	input  wire logic chg_lvl,
	input  wire logic pin_o,
	input  wire logic pin_oe_n,
	output logic      integ_clk,
	output logic      integ_up,
	output logic      pin_lvl
);
	// ====================
	// Integrator steps only inside a burst; direction changes while the clock is low.
	initial integ_clk = 1'b0;
	initial integ_up = 1'b1;
	always begin
		wait (run);
		integ_up = up;
		#173 integ_clk = 1'b1;
		#147 integ_clk = 1'b0;
	end
	// The charger drives only when fitted; otherwise the pull-up wins.
	assign pin_lvl = !pin_oe_n ? pin_o : (chg_en ? chg_lvl : 1'b1);
endmodule : cgal_far_model

// ---- bench/charge_gauge_alert_logic_test.sv ----
`timescale 1ns/1ns
module charge_gauge_alert_logic_test
	import cgal_pkg::*;
;
	// ====================
	// Stimulus, partner and result queue.
	localparam logic [15:0] RTAB [12] = '{16'h0000, 16'h013c, 16'h027f, 16'h03ff, 16'h04ff,
		16'h05ff, 16'h0600, 16'h0700, 16'h0aff, 16'h0b00, 16'h0eff, 16'h0f00};
	localparam logic [4:0]  RA [6]    = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h0a, 5'h0e};
	logic        clk, reset_n, reg_wr, reg_rd, integ_clk, integ_up, adc_volt_vld, adc_temp_vld;
	logic        shutdown, pin_i, pin_o, pin_oe_n, irq, run, up, chg_en, chg_lvl;
	logic        pend = 1'b0;
	logic [4:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, d;
	logic [15:0] adc_volt, adc_temp;
	logic [1:0]  adc_mode;
	logic [31:0] seed;
	logic [7:0]  exq[$];
	int          err_count = 0;
	int          num_checks = 0;
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	cgal_top uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .integ_clk(integ_clk),
		.integ_up(integ_up), .adc_volt(adc_volt), .adc_volt_vld(adc_volt_vld),
		.adc_temp(adc_temp), .adc_temp_vld(adc_temp_vld), .adc_mode(adc_mode),
		.shutdown(shutdown), .alert_or_charge_done_pin_i(pin_i), .alert_or_charge_done_pin_o(pin_o),
		.alert_or_charge_done_pin_oe_n(pin_oe_n), .irq(irq));
	cgal_far_model far (.run(run), .up(up), .chg_en(chg_en), .chg_lvl(chg_lvl), .pin_o(pin_o),
		.pin_oe_n(pin_oe_n), .integ_clk(integ_clk), .integ_up(integ_up), .pin_lvl(pin_i));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run
	// A read notes its expected byte; the monitor compares it in the following cycle.
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		{reg_wr, reg_rd} <= {w, !w};
		if (!w) exq.push_back(v);
		@(posedge clk);
		{reg_wr, reg_rd} <= 2'h0;
	endtask : bus
	task automatic b16(input logic w, input logic [4:0] a, input logic [15:0] v);
		bus(w, a, v[15:8]);
		bus(w, a + 5'h01, v[7:0]);
	endtask : b16
	task automatic stp(input int n, input logic dir);
		up <= dir;
		run <= 1'b1;
		repeat (n) @(posedge integ_clk);
		run <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : stp
	task automatic adc(input logic [15:0] v, input logic [15:0] t);
		@(posedge clk);
		adc_volt <= v;
		adc_temp <= t;
		{adc_volt_vld, adc_temp_vld} <= 2'h3;
		@(posedge clk);
		{adc_volt_vld, adc_temp_vld} <= 2'h0;
	endtask : adc
	task automatic pins(input logic e_oe, input logic e_irq);
		repeat (4) @(posedge clk);
		@(negedge clk);
		cmp("pin_oe_n", {15'h0000, e_oe}, {15'h0000, pin_oe_n});
		cmp("irq", {15'h0000, e_irq}, {15'h0000, irq});
	endtask : pins
	always @(negedge clk) begin
		if (pend) cmp("reg_rdata", {8'h00, exq.pop_front()}, {8'h00, reg_rdata});
		pend = reg_rd;
	end
	initial begin
		#2000000;
		err_count++;
		complete_run();
	end
	initial begin
		{reg_wr, reg_rd, adc_volt_vld, adc_temp_vld, run, up, chg_en, chg_lvl} = '0;
		{reg_addr, reg_wdata, adc_volt, adc_temp} = '0;
		reset_n = 1'b0;
		seed = 32'h000168ce;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		foreach (RTAB[i]) bus(1'b0, RTAB[i][12:8], RTAB[i][7:0]);
		pins(1'b1, 1'b0);
		$display("test reset done");
		foreach (RA[i]) begin
			seed = lfsr(seed);
			d = seed[7:0];
			if (RA[i] == OFS_QTH_HM) d[7] = 1'b1;
			if (RA[i] == OFS_QTH_LM) d[7] = 1'b0;
			bus(1'b1, RA[i], d);
			bus(1'b0, RA[i], d);
		end
		bus(1'b1, OFS_VOLT_M, 8'h5a);
		bus(1'b0, OFS_VOLT_M, 8'h00);
		bus(1'b0, 5'h12, 8'h00);
		for (int i = 4; i < 12; i++) bus(1'b1, RTAB[i][12:8], RTAB[i][7:0]);
		$display("test limits done");
		b16(1'b1, OFS_ACR_HI, 16'h1000);
		for (int k = 0; k < 8; k++) begin
			bus(1'b1, OFS_CTRL, {2'h0, k[2:0], PIN_ALERT, 1'b0});
			stp(2 << k, 1'b1);
			stp(1 << k, 1'b0);
			b16(1'b0, OFS_ACR_HI, 16'h1001 + k[15:0]);
		end
		bus(1'b1, OFS_CTRL, 8'h05);
		stp(3, 1'b1);
		b16(1'b0, OFS_ACR_HI, 16'h1008);
		$display("test prescale done");
		bus(1'b1, OFS_CTRL, 8'h04);
		b16(1'b1, OFS_QTH_HM, 16'h2000);
		b16(1'b1, OFS_ACR_HI, 16'h3000);
		pins(1'b0, 1'b0);
		bus(1'b0, OFS_STAT, 8'h08);
		b16(1'b1, OFS_ACR_HI, 16'h1000);
		bus(1'b0, OFS_STAT, 8'h08);
		bus(1'b0, OFS_STAT, 8'h00);
		pins(1'b1, 1'b0);
		b16(1'b1, OFS_QTH_HM, 16'hffff);
		$display("test charge alert done");
		bus(1'b1, OFS_IRQ_MK, 8'h02);
		bus(1'b1, OFS_IRQ_ST, 8'hff);
		b16(1'b1, OFS_ACR_HI, 16'hfffe);
		stp(3, 1'b1);
		b16(1'b0, OFS_ACR_HI, 16'hffff);
		pins(1'b1, 1'b1);
		bus(1'b1, OFS_IRQ_ST, 8'h02);
		pins(1'b1, 1'b0);
		b16(1'b1, OFS_ACR_HI, 16'h0001);
		stp(3, 1'b0);
		b16(1'b0, OFS_ACR_HI, 16'h0000);
		bus(1'b0, OFS_STAT, 8'h20);
		bus(1'b1, OFS_IRQ_MK, 8'h00);
		pins(1'b1, 1'b0);
		$display("test saturation done");
		chg_en <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, OFS_CTRL, {5'h00, c[1:0], 1'b0});
			bus(1'b0, OFS_CTRL, {5'h00, c[1:0], 1'b0});
			b16(1'b1, OFS_ACR_HI, 16'h1000);
			chg_lvl <= 1'b1;
			repeat (30) @(posedge clk);
			stp(2, 1'b0);
			b16(1'b0, OFS_ACR_HI, c == 1 ? 16'hffff : 16'h0ffe);
			chg_lvl <= 1'b0;
			stp(2, 1'b0);
			b16(1'b0, OFS_ACR_HI, c == 1 ? 16'hfffd : 16'h0ffc);
		end
		chg_en <= 1'b0;
		$display("test charge done input done");
		bus(1'b1, OFS_CTRL, CTRL_RST);
		repeat (3) begin
			seed = lfsr(seed);
			adc(seed[15:0], seed[31:16]);
			b16(1'b0, OFS_VOLT_M, seed[15:0] & VOLT_MASK);
			b16(1'b0, OFS_TEMP_M, seed[31:16] & TEMP_MASK);
		end
		bus(1'b1, OFS_VTH_HI, 8'h7f);
		bus(1'b1, OFS_TTH_LO, 8'h20);
		adc(16'h8123, 16'h1040);
		pins(1'b0, 1'b0);
		bus(1'b0, OFS_STAT, 8'h32);
		bus(1'b1, OFS_VTH_HI, 8'hff);
		bus(1'b1, OFS_TTH_LO, 8'h00);
		bus(1'b0, OFS_STAT, 8'h12);
		bus(1'b0, OFS_STAT, 8'h00);
		pins(1'b1, 1'b0);
		$display("test results done");
		complete_run();
	end
endmodule : charge_gauge_alert_logic_test
